// >>> logic/blank_timer.sv
// comparator blanking after each bridge switching event
`timescale 1ns/100ps
module blank_timer
  import chopper_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [1:0] blank_time_select,
  input wire logic switch_event,
  output logic mask
);
  logic [5:0] cnt;
  logic [5:0] len;

  always_comb begin
    unique case (blank_time_select)
      2'h0: len = BLANK0;
      2'h1: len = BLANK1;
      2'h2: len = BLANK2;
      2'h3: len = BLANK3;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= 6'h00;
      mask <= 1'b0;
    end else if (ce) begin
      if (switch_event) begin
        cnt <= 6'(len - 6'h01);
        mask <= 1'b1;
      end else if (cnt != 6'h00) begin
        cnt <= 6'(cnt - 6'h01);
      end else begin
        mask <= 1'b0;
      end
    end
  end

  AST_BLANK_START: assert property (@(posedge clk) disable iff (srst)
    (ce && switch_event) |=> mask ##1 mask[*8])
    else $error("blank mask too short");
endmodule

// >>> logic/chopper_pkg.sv
// shared constants and types of the voltage chopper configuration block
package chopper_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_GLOBAL_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_UPPER_VELOCITY = 8'h04;
  localparam logic [7:0] ADDR_PWM_CONF = 8'h08;
  localparam logic [7:0] ADDR_CHOP_CONF = 8'h0c;
  localparam logic [7:0] ADDR_CURRENT = 8'h10;
  localparam logic [7:0] ADDR_POWERDOWN = 8'h14;
  localparam logic [7:0] ADDR_SCALE = 8'h18;
  localparam logic [7:0] ADDR_TUNED = 8'h1c;
  localparam logic [7:0] ADDR_STATE = 8'h20;
  // field positions
  localparam int POS_CUR_SEL = 0;
  localparam int POS_AUTOSCALE = 1;
  localparam int POS_AUTOGRAD = 2;
  localparam int POS_OFS = 0;
  localparam int POS_GRAD = 8;
  localparam int POS_FREQ = 16;
  localparam int POS_GAIN = 18;
  localparam int POS_LIM = 22;
  localparam int POS_OPTION = 26;
  localparam int POS_SLOW_DECAY_TIME = 0;
  localparam int POS_TBL = 4;
  localparam int POS_HOLD = 0;
  localparam int POS_RUN = 8;
  localparam int POS_RAMP = 16;
  localparam int POS_AMPL = 8;
  // reset values
  localparam logic [3:0] RST_LIM = 4'hc;
  localparam logic [3:0] RST_GAIN = 4'h4;
  localparam logic [1:0] RST_FREQ = 2'h1;
  localparam logic [3:0] RST_SLOW_DECAY_TIME = 4'h0;
  localparam logic [1:0] RST_TBL = 2'h2;
  localparam logic [4:0] RST_RUN = 5'h10;
  localparam logic [4:0] RST_HOLD = 5'h08;
  // timing counts
  localparam logic [10:0] PWM_DIV0 = 11'd1024;
  localparam logic [10:0] PWM_DIV1 = 11'd683;
  localparam logic [10:0] PWM_DIV2 = 11'd512;
  localparam logic [10:0] PWM_DIV3 = 11'd410;
  localparam logic [5:0] BLANK0 = 6'd16;
  localparam logic [5:0] BLANK1 = 6'd24;
  localparam logic [5:0] BLANK2 = 6'd32;
  localparam logic [5:0] BLANK3 = 6'd40;
  localparam logic [4:0] LIMIT_PERIODS = 5'd16;
  localparam logic signed [9:0] CORR_MAX = 10'sd510;

  typedef enum logic [1:0] {SS_NORMAL, SS_STANDSTILL_OPTION, SS_SHORT_LOW, SS_SHORT_HIGH} standstill_t;
  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_HOLD} phase_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic driver_enable;
    logic voltage_mode;
    standstill_t standstill;
    logic [7:0] amplitude;
  } bridge_cmd_t;
endpackage

// >>> logic/pwm_divider.sv
// voltage pwm period generator with half-cycle resolution
`timescale 1ns/100ps
module pwm_divider
  import chopper_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [1:0] rate,
  output logic tick
);
  logic [10:0] acc;
  logic [10:0] div;

  always_comb begin
    unique case (rate)
      2'h0: div = PWM_DIV0;
      2'h1: div = PWM_DIV1;
      2'h2: div = PWM_DIV2;
      2'h3: div = PWM_DIV3;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      acc <= 11'h000;
      tick <= 1'b0;
    end else if (ce) begin
      if (acc + 11'h002 >= div) begin
        acc <= 11'(acc + 11'h002 - div);
        tick <= 1'b1;
      end else begin
        acc <= 11'(acc + 11'h002);
        tick <= 1'b0;
      end
    end
  end
endmodule

// >>> logic/voltage_chopper_standstill_config.sv
// standstill, mode select and amplitude scaling of the voltage chopper
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
module voltage_chopper_standstill_config
  import chopper_pkg::*;
#(
  parameter int unsigned POWERDOWN_UNIT = 32'd262144,
  parameter int unsigned HOLD_RAMP_UNIT = 32'd131072
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire bus_req_t bus,
  output logic [31:0] rdata,
  input wire logic chopper_select_pin,
  input wire logic [19:0] microstep_interval,
  input wire logic motor_standstill,
  input wire logic fullstep,
  input wire logic current_low,
  input wire logic [7:0] otp_gradient,
  input wire logic switch_event,
  output bridge_cmd_t bridge,
  output logic comparator_mask
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic cur_sel;
  logic autoscale;
  logic autograd;
  logic [19:0] upper_velocity;
  logic [7:0] amplitude_offset;
  logic [7:0] amplitude_gradient;
  logic [1:0] voltage_pwm_rate_select;
  logic [3:0] reg_gain;
  logic [3:0] switchover_amplitude_limit;
  logic [1:0] standstill_option;
  logic [3:0] slow_decay_time;
  logic [1:0] blank_time_select;
  logic [4:0] hold_current_setting;
  logic [4:0] run_current;
  logic [3:0] hold_ramp_delay;
  logic [7:0] powerdown_delay;
  logic sel_meta;
  logic sel_sync;
  logic pwm_tick;
  logic voltage_mode;
  logic [1:0] option_applied;
  logic jerk_limit;
  logic [4:0] limit_count;
  phase_t phase;
  logic [31:0] delay_count;
  logic [31:0] delay_total;
  logic target_zero;
  logic frozen;
  logic signed [9:0] corr_half;
  logic signed [8:0] scale_correction;
  logic signed [9:0] gain_step;
  logic [7:0] tuned_offset;
  logic [7:0] tuned_gradient;
  logic eff_sel;
  logic next_voltage;
  logic standstill_active;
  logic [7:0] next_amplitude;

  function automatic standstill_t decode_option(input logic [1:0] code);
    standstill_t mode;
    unique case (code)
      2'h0: mode = SS_NORMAL;
      2'h1: mode = SS_STANDSTILL_OPTION;
      2'h2: mode = SS_SHORT_LOW;
      2'h3: mode = SS_SHORT_HIGH;
    endcase
    return mode;
  endfunction

  // coarse grad*256/interval: shift by the interval's msb position
  function automatic logic [8:0] velocity_term(input logic [7:0] grad,
                                               input logic [19:0] interval);
    logic [4:0] msb;
    logic [15:0] prod;
    msb = 5'd0;
    for (int i = 0; i < 20; i++) begin
      if (interval[i]) begin
        msb = 5'(i);
      end
    end
    prod = {grad, 8'h00} >> msb;
    return (prod > 16'h00ff) ? 9'h0ff : prod[8:0];
  endfunction

  function automatic logic [7:0] step8(input logic [7:0] v, input logic up);
    if (up) begin
      return (v == 8'hff) ? v : 8'(v + 8'h01);
    end
    return (v == 8'h00) ? v : 8'(v - 8'h01);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register writes

  always_ff @(posedge clk) begin
    if (srst) begin
      cur_sel <= 1'b0;
      autoscale <= 1'b1;
      autograd <= 1'b1;
      upper_velocity <= 20'h00000;
    end else if (ce && bus.wr) begin
      if (bus.addr == ADDR_GLOBAL_CONFIG) begin
        cur_sel <= bus.wdata[POS_CUR_SEL];
        autoscale <= bus.wdata[POS_AUTOSCALE];
        autograd <= bus.wdata[POS_AUTOGRAD];
      end
      if (bus.addr == ADDR_UPPER_VELOCITY) begin
        upper_velocity <= bus.wdata[19:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      amplitude_offset <= 8'h00;
      amplitude_gradient <= otp_gradient;
      voltage_pwm_rate_select <= RST_FREQ;
      reg_gain <= RST_GAIN;
      switchover_amplitude_limit <= RST_LIM;
      standstill_option <= 2'h0;
    end else if (ce && bus.wr && bus.addr == ADDR_PWM_CONF) begin
      amplitude_offset <= bus.wdata[POS_OFS +: 8];
      amplitude_gradient <= bus.wdata[POS_GRAD +: 8];
      voltage_pwm_rate_select <= bus.wdata[POS_FREQ +: 2];
      // gain zero is not a legal setting
      reg_gain <= (bus.wdata[POS_GAIN +: 4] == 4'h0) ? 4'h1 : bus.wdata[POS_GAIN +: 4];
      switchover_amplitude_limit <= bus.wdata[POS_LIM +: 4];
      standstill_option <= bus.wdata[POS_OPTION +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      slow_decay_time <= RST_SLOW_DECAY_TIME;
      blank_time_select <= RST_TBL;
      hold_current_setting <= RST_HOLD;
      run_current <= RST_RUN;
      hold_ramp_delay <= 4'h0;
      powerdown_delay <= 8'h00;
    end else if (ce && bus.wr) begin
      if (bus.addr == ADDR_CHOP_CONF) begin
        slow_decay_time <= bus.wdata[POS_SLOW_DECAY_TIME +: 4];
        blank_time_select <= bus.wdata[POS_TBL +: 2];
      end
      if (bus.addr == ADDR_CURRENT) begin
        hold_current_setting <= bus.wdata[POS_HOLD +: 5];
        run_current <= bus.wdata[POS_RUN +: 5];
        hold_ramp_delay <= bus.wdata[POS_RAMP +: 4];
      end
      if (bus.addr == ADDR_POWERDOWN) begin
        powerdown_delay <= bus.wdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register reads, unmapped addresses read zero

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 32'h00000000;
    end else if (ce) begin
      rdata <= 32'h00000000;
      if (bus.rd) begin
        unique case (bus.addr)
          ADDR_GLOBAL_CONFIG: rdata <= {29'h0, autograd, autoscale, cur_sel};
          ADDR_UPPER_VELOCITY: rdata <= {12'h000, upper_velocity};
          ADDR_PWM_CONF: rdata <= {4'h0, standstill_option, switchover_amplitude_limit,
                                   reg_gain, voltage_pwm_rate_select,
                                   amplitude_gradient, amplitude_offset};
          ADDR_CHOP_CONF: rdata <= {26'h0, blank_time_select, slow_decay_time};
          ADDR_CURRENT: rdata <= {12'h000, hold_ramp_delay, 3'h0, run_current,
                                  3'h0, hold_current_setting};
          ADDR_POWERDOWN: rdata <= {24'h000000, powerdown_delay};
          ADDR_SCALE: rdata <= {{23{scale_correction[8]}}, scale_correction};
          ADDR_TUNED: rdata <= {16'h0000, tuned_gradient, tuned_offset};
          ADDR_STATE: rdata <= {16'h0000, bridge.amplitude, 3'h0, bridge.driver_enable,
                                bridge.standstill, standstill_active, voltage_mode};
          default: rdata <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin sync, pwm timebase and blanking

  always_ff @(posedge clk) begin
    if (srst) begin
      sel_meta <= 1'b0;
      sel_sync <= 1'b0;
    end else if (ce) begin
      sel_meta <= chopper_select_pin;
      sel_sync <= sel_meta;
    end
  end

  pwm_divider u_pwm (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .rate(voltage_pwm_rate_select),
    .tick(pwm_tick)
  );

  blank_timer u_blank (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .blank_time_select(blank_time_select),
    .switch_event(switch_event),
    .mask(comparator_mask)
  );

  ////////////////////////////////////////////////////////////////////////
  // chopper mode select

  assign eff_sel = cur_sel ^ sel_sync;
  assign next_voltage = !eff_sel && !(microstep_interval < upper_velocity);

  // mode only changes on a pwm boundary to avoid partial periods
  always_ff @(posedge clk) begin
    if (srst) begin
      voltage_mode <= 1'b0;
      option_applied <= 2'h0;
    end else if (ce && pwm_tick) begin
      voltage_mode <= next_voltage;
      option_applied <= standstill_option;
    end
  end

  // limit amplitude for a while after entering voltage mode
  always_ff @(posedge clk) begin
    if (srst) begin
      jerk_limit <= 1'b0;
      limit_count <= 5'h00;
    end else if (ce && pwm_tick) begin
      if (next_voltage && !voltage_mode) begin
        jerk_limit <= 1'b1;
        limit_count <= LIMIT_PERIODS;
      end else if (limit_count != 5'h00) begin
        limit_count <= 5'(limit_count - 5'h01);
      end else begin
        jerk_limit <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // standstill sequence

  assign delay_total = 32'(powerdown_delay * POWERDOWN_UNIT)
                     + 32'(hold_ramp_delay * HOLD_RAMP_UNIT);

  always_ff @(posedge clk) begin
    if (srst) begin
      phase <= ST_RUN;
      delay_count <= 32'h00000000;
    end else if (ce) begin
      unique case (phase)
        ST_RUN: begin
          delay_count <= 32'h00000000;
          if (motor_standstill) begin
            phase <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!motor_standstill) begin
            phase <= ST_RUN;
          end else if (delay_count >= delay_total) begin
            phase <= ST_HOLD;
          end else begin
            delay_count <= 32'(delay_count + 32'h1);
          end
        end
        ST_HOLD: begin
          if (!motor_standstill) begin
            phase <= ST_RUN;
          end
        end
        default: phase <= ST_RUN;
      endcase
    end
  end

  assign standstill_active = (phase == ST_HOLD) && (hold_current_setting == 5'h00);
  assign target_zero = (phase == ST_HOLD) ? (hold_current_setting == 5'h00)
                                          : (run_current == 5'h00);

  ////////////////////////////////////////////////////////////////////////
  // current regulator and tuning

  assign frozen = !voltage_mode || target_zero || !autoscale;
  assign scale_correction = 9'(corr_half >>> 1);
  // signed gain keeps the clamp compares signed
  assign gain_step = signed'(10'(reg_gain));

  // gain counts half steps per fullstep
  always_ff @(posedge clk) begin
    if (srst) begin
      corr_half <= 10'sd0;
    end else if (ce && fullstep && !frozen) begin
      if (current_low) begin
        corr_half <= (corr_half > CORR_MAX - gain_step) ? CORR_MAX
                   : 10'(corr_half + gain_step);
      end else begin
        corr_half <= (corr_half < gain_step - CORR_MAX) ? -CORR_MAX
                   : 10'(corr_half - gain_step);
      end
    end
  end

  // tuning starts from the programmed values once autoscale has been off; after reset it starts from zero
  always_ff @(posedge clk) begin
    if (srst) begin
      tuned_offset <= 8'h00;
      tuned_gradient <= 8'h00;
    end else if (ce) begin
      if (!autoscale) begin
        tuned_offset <= amplitude_offset;
        tuned_gradient <= amplitude_gradient;
      end else if (!autograd) begin
        tuned_gradient <= amplitude_gradient;
        if (fullstep && !frozen && motor_standstill) begin
          tuned_offset <= step8(tuned_offset, current_low);
        end
      end else if (fullstep && !frozen) begin
        if (motor_standstill) begin
          tuned_offset <= step8(tuned_offset, current_low);
        end else begin
          tuned_gradient <= step8(tuned_gradient, current_low);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // amplitude and bridge command

  always_comb begin
    logic [7:0] ofs_used;
    logic [7:0] grad_used;
    logic [4:0] cs;
    logic [12:0] ofs_scaled;
    logic signed [11:0] sum;
    logic [7:0] lim8;
    ofs_used = autoscale ? tuned_offset : amplitude_offset;
    grad_used = autoscale ? tuned_gradient : amplitude_gradient;
    cs = (phase == ST_HOLD) ? hold_current_setting : run_current;
    // zero programmed offset forces the offset term to zero, even a tuned one
    ofs_scaled = (amplitude_offset == 8'h00) ? 13'h0000
               : 13'((ofs_used * (cs + 5'h01)) >> 5);
    sum = 12'(ofs_scaled) + 12'(velocity_term(grad_used, microstep_interval));
    if (autoscale) begin
      sum = 12'(sum + 12'(scale_correction));
    end
    if (sum < 12'sd0) begin
      next_amplitude = 8'h00;
    end else if (sum > 12'sd255) begin
      next_amplitude = 8'hff;
    end else begin
      next_amplitude = sum[7:0];
    end
    lim8 = {switchover_amplitude_limit, 4'hf};
    if (jerk_limit && next_amplitude > lim8) begin
      next_amplitude = lim8;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bridge <= '{1'b0, 1'b0, SS_NORMAL, 8'h00};
    end else if (ce) begin
      // zero slow decay time turns the driver off
      bridge.driver_enable <= (slow_decay_time != 4'h0);
      bridge.voltage_mode <= voltage_mode;
      bridge.standstill <= (standstill_active && voltage_mode)
                         ? decode_option(option_applied) : SS_NORMAL;
      bridge.amplitude <= next_amplitude;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  AST_STANDSTILL_HOLD: assert property (
    (bridge.standstill != SS_NORMAL) |-> ($past(hold_current_setting) == 5'h00))
    else $error("standstill option with nonzero hold current");

  AST_STANDSTILL_DELAY: assert property (
    $rose(phase == ST_HOLD) |-> $past(delay_count) >= $past(delay_total))
    else $error("standstill entered before delay elapsed");

  AST_FREEZE: assert property (
    frozen |=> corr_half == $past(corr_half))
    else $error("regulator moved while frozen");

  AST_SELECT_XOR: assert property (
    (ce && pwm_tick && (cur_sel ^ sel_sync)) |=> !voltage_mode ##1 !bridge.voltage_mode)
    else $error("voltage mode despite chopper select");

  AST_VELOCITY: assert property (
    (ce && pwm_tick && microstep_interval < upper_velocity) |=> !voltage_mode)
    else $error("voltage mode above upper velocity");

  AST_SWITCH_LIMIT: assert property (
    (ce && jerk_limit) |=> bridge.amplitude <= {$past(switchover_amplitude_limit), 4'hf})
    else $error("amplitude above switchover limit");

  AST_CORR_RANGE: assert property (
    scale_correction <= 9'sd255 && scale_correction >= -9'sd255)
    else $error("scale correction out of range");

  AST_DRIVER_OFF: assert property (
    (ce && slow_decay_time == 4'h0) |=> !bridge.driver_enable)
    else $error("driver enabled with zero slow decay time");

  AST_BOUNDARY: assert property (
    !(ce && pwm_tick) |=> $stable(voltage_mode) && $stable(option_applied))
    else $error("mode changed off a pwm boundary");
endmodule

// >>> tb/bridge_model.sv
// motor bridge stand-in: switching events and current comparison
`timescale 1ns/100ps
module bridge_model
  import chopper_pkg::*;
#(
  parameter int PERIOD = 64,
  parameter logic [7:0] TARGET = 8'hc8
) (
  input wire logic clk,
  input wire bridge_cmd_t bridge,
  output logic switch_event,
  output logic current_low
);
  int cnt = 0;
  ////////////////////////////////////////////////////////////////////////
  // a braked or floating bridge never switches, so no blanking then
  always @(posedge clk) begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    switch_event <= bridge.driver_enable && bridge.standstill == SS_NORMAL && cnt == 0;
    current_low <= bridge.amplitude < TARGET;
  end
endmodule

// >>> tb/voltage_chopper_standstill_config_test.sv
// self-checking bench of the voltage chopper configuration block
`timescale 1ns/100ps
module voltage_chopper_standstill_config_test
  import chopper_pkg::*;
;
  logic clk = 0, srst = 1, ce = 1, pin = 0, standstill = 0, fullstep = 0;
  logic [19:0] interval = 20'hfffff;
  bus_req_t bus = '0;
  logic [31:0] rdata, d;
  bridge_cmd_t bridge;
  logic switch_event, current_low, mask;
  int fails = 0, n_tests = 0, n, m;
  always #20 clk = ~clk;
  // short delay units keep standstill entry within a few cycles
  voltage_chopper_standstill_config #(.POWERDOWN_UNIT(4), .HOLD_RAMP_UNIT(2)) dut (
    .clk(clk), .srst(srst), .ce(ce), .bus(bus), .rdata(rdata), .chopper_select_pin(pin),
    .microstep_interval(interval), .motor_standstill(standstill), .fullstep(fullstep),
    .current_low(current_low), .otp_gradient(8'h5a), .switch_event(switch_event),
    .bridge(bridge), .comparator_mask(mask));
  bridge_model partner (.clk(clk), .bridge(bridge), .switch_event(switch_event),
    .current_low(current_low));
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk) bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus <= '0;
    #1 d = rdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask
  task automatic steps(input int k);
    repeat (k) begin
      @(posedge clk) fullstep <= 1'b1;
      @(posedge clk) fullstep <= 1'b0;
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic waitm(input logic v);
    for (int k = 0; k < 200 && mask !== v; k++) @(posedge clk);
  endtask
  // cycles up to the next pwm boundary
  task automatic waitt(output int c);
    c = 0;
    @(posedge clk);
    c++;
    while (dut.pwm_tick !== 1'b1 && c < 2000) begin
      @(posedge clk);
      c++;
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    idle(30000);
    fails++;
    tally_and_finish();
  end
  initial begin
    idle(10);
    srst <= 1'b0;
    rchk(ADDR_PWM_CONF, (32'h5a << POS_GRAD) | (32'h1 << POS_FREQ) | (32'h4 << POS_GAIN) | (32'hc << POS_LIM));
    rchk(ADDR_GLOBAL_CONFIG, 32'h6);
    rchk(8'h40, 32'h0);
    chk(bridge.driver_enable, 1'b0);
    done("reset");
    // gain 4 moves the correction two units per fullstep
    idle(800);
    rchk(ADDR_SCALE, 32'h0);
    steps(5);
    rchk(ADDR_SCALE, 32'ha);
    wr(ADDR_CURRENT, 32'h8);
    steps(5);
    rchk(ADDR_SCALE, 32'ha);
    wr(ADDR_CURRENT, 32'h1008);
    wr(ADDR_GLOBAL_CONFIG, 32'h7);
    idle(800);
    steps(5);
    rchk(ADDR_SCALE, 32'ha);
    done("regulator");
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_GLOBAL_CONFIG, 32'h6 | i[0]);
      pin <= i[1];
      idle(800);
      rd(ADDR_STATE);
      chk(d[0], !(i[0] ^ i[1]));
      chk(bridge.voltage_mode, !(i[0] ^ i[1]));
    end
    wr(ADDR_UPPER_VELOCITY, 32'd100);
    interval <= 20'd50;
    idle(800);
    chk(bridge.voltage_mode, 1'b0);
    interval <= 20'd100;
    idle(800);
    chk(bridge.voltage_mode, 1'b1);
    done("mode select");
    // total delay is 2 * 4 + 1 * 2 = 10 cycles
    wr(ADDR_POWERDOWN, 32'h2);
    for (int o = 0; o < 6; o++) begin
      wr(ADDR_CURRENT, 32'h11000 | 32'(o >> 2));
      wr(ADDR_PWM_CONF, (32'h3 << POS_FREQ) | (32'h4 << POS_GAIN) | (32'(o & 3) << POS_OPTION));
      idle(300);
      standstill <= 1'b1;
      idle(4);
      chk(bridge.standstill, SS_NORMAL);
      idle(20);
      chk(bridge.standstill, (o > 3) ? 2'h0 : 2'(o));
      standstill <= 1'b0;
      idle(4);
    end
    done("standstill");
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CHOP_CONF, 32'h1 | (32'(c) << POS_TBL));
      idle(2);
      chk(bridge.driver_enable, 1'b1);
      n = 0;
      waitm(1'b0);
      waitm(1'b1);
      while (mask === 1'b1 && n < 100) begin
        @(posedge clk);
        n++;
      end
      chk(n, 16 + 8 * c);
    end
    wr(ADDR_CHOP_CONF, 32'h0);
    idle(2);
    chk(bridge.driver_enable, 1'b0);
    done("blanking");
    wr(ADDR_GLOBAL_CONFIG, 32'h0);
    wr(ADDR_PWM_CONF, 32'h4433 | (32'h4 << POS_GAIN));
    wr(ADDR_TUNED, 32'h0);
    rchk(ADDR_TUNED, 32'h4433);
    wr(ADDR_GLOBAL_CONFIG, 32'h2);
    steps(3);
    rd(ADDR_TUNED);
    chk(d[15:8], 8'h44);
    done("tuning");
    // offset 0x40 at run current 16, no gradient: 0x40 * 17 / 32
    wr(ADDR_GLOBAL_CONFIG, 32'h0);
    wr(ADDR_PWM_CONF, 32'h40 | (32'h4 << POS_GAIN) | (32'hf << POS_LIM));
    idle(2);
    chk(bridge.amplitude, 8'h22);
    // two pwm periods span the full divider count
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_PWM_CONF, (32'(r) << POS_FREQ) | (32'h4 << POS_GAIN));
      repeat (3) waitt(n);
      waitt(m);
      waitt(n);
      chk(m + n, (r == 0) ? 1024 : (r == 1) ? 683 : (r == 2) ? 512 : 410);
    end
    done("rate and offset");
    tally_and_finish();
  end
endmodule
